//--- parallel_command_port.sv
// Parallel command and trigger port with APB register access
// Overview of operation
// RULE1 - Trigger edge starts exactly one measurement
// RULE2 - Receive-ready permits result presentation
// RULE3 - Host sets info before execute
// RULE4 - Command 00 measures continuously
// RULE5 - Command 01 selects scene number
// RULE6 - Command 11 selects scene group
// RULE7 - Clear 00000 clears stored values
// RULE8 - Clear 00001 clears error
// RULE9 - Clear 00010 clears result outputs
// RULE10 - Multi-line gives each line own signals
// RULE11 - Multi-line splits results eight plus eight
// RULE12 - Diagnostic mode forces every output; the code forces the line outputs, result_out and error_out, but not irq
// RULE13 - All input levels readable
// RULE14 - Bad command sets error output
// RULE15 - Sample command on execute edge
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps

`include "parallel_command_port_regs.svh"

module parallel_command_port (
    // APB slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // External inputs
    input  wire logic        line0_trigger,
    input  wire logic        line1_trigger,
    input  wire logic        line0_rx_ready_in,
    input  wire logic        line1_rx_ready_in,
    input  wire logic [7:0]  cmd_in,
    // Measurement results supplied by the processing core
    input  wire logic [15:0] meas_result,
    input  wire logic        meas_ok0,
    input  wire logic        meas_ok1,
    // External outputs
    output logic             line0_result_strobe,
    output logic             line1_result_strobe,
    output logic             line0_overall_result,
    output logic             line1_overall_result,
    output logic             line0_accept_ready,
    output logic             line1_accept_ready,
    output logic [15:0]      result_out,
    output logic             error_out,
    // Core controls
    output logic             meas_start0,
    output logic             meas_start1,
    output logic             clear_values,
    output logic             irq
);

    // =================================================================
    // Declarations
    logic [2:0]  ctrl;          // Multi, diagnostic, handshake
    logic [2:0]  next_ctrl;
    logic [22:0] force_out;     // Forced output levels
    logic [22:0] next_force_out;
    logic [4:0]  scene;         // Current scene number
    logic [4:0]  next_scene;
    logic [4:0]  group;         // Current scene group
    logic [4:0]  next_group;
    logic [4:0]  irq_status;    // Sticky event bits
    logic [4:0]  next_irq_status;
    logic [4:0]  irq_enable;    // Interrupt enables
    logic [4:0]  next_irq_enable;
    logic [15:0] result;        // Held result bits
    logic [15:0] next_result;
    logic [1:0]  overall;       // Held overall results
    logic [1:0]  next_overall;
    logic        err;           // Error flag
    logic        next_err;
    logic        exec_q;        // Previous execute level
    logic        next_exec_q;
    logic [14:0] stable_cnt;    // Cycles the info bits stood still
    logic [14:0] next_stable_cnt;
    logic [6:0]  info_q;        // Info bits last cycle
    logic [6:0]  next_info_q;
    logic [31:0] next_prdata;
    logic        clear_pulse;   // Combinational one-cycle clear
    logic [4:0]  events;        // Events this cycle
    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;
    logic        exec_edge;
    logic        cont_run;
    logic        multi;
    logic        diag;
    logic        strobe0;
    logic        strobe1;
    logic        rdy0;
    logic        rdy1;
    logic        cont0;
    logic        cont1;
    logic        sel_line1;

    localparam logic [14:0] SETUP_CYC = 15'(`PCP_CMD_SETUP_CYC);

    assign multi     = ctrl[`PCP_CTRL_MULTI_BIT];
    assign diag      = ctrl[`PCP_CTRL_DIAG_BIT];
    assign wr_en     = psel && penable && pwrite;
    // Read data is latched in the setup cycle so it stands through the access phase
    assign rd_en     = psel && !penable && !pwrite;
    // RULE15 rising edge of execute
    assign exec_edge = cmd_in[7] && !exec_q;
    // RULE4 continuous while command held
    assign cont_run  = cmd_in[7] &&
                       (parallel_command_port_pkg::cmd_field_e'(cmd_in[6:5]) ==
                        parallel_command_port_pkg::CMD_CONTINUOUS);
    // In multi-line mode bit 4 selects the line
    assign sel_line1 = multi && cmd_in[4];
    assign cont0     = cont_run && !sel_line1;
    assign cont1     = cont_run && sel_line1;

    // =================================================================
    // Address decode
    always_comb begin
        case (paddr)
            `PCP_CTRL_OFS, `PCP_IN_STATUS_OFS, `PCP_FORCE_OUT_OFS, `PCP_SCENE_OFS,
            `PCP_IRQ_STATUS_OFS, `PCP_IRQ_CLEAR_OFS, `PCP_IRQ_ENABLE_OFS,
            `PCP_RESULT_OFS: addr_ok = 1'b1;
            default:         addr_ok = 1'b0;
        endcase
    end

    // =================================================================
    // RULE10 two independent lines
    pcp_line_ctrl u_line0 (
        .pclk          (pclk),
        .presetn       (presetn),
        .trigger       (line0_trigger && !diag),
        .continuous    (cont0 && !diag),
        .rx_ready      (line0_rx_ready_in),
        .handshake     (ctrl[`PCP_CTRL_HSHK_BIT]),
        .meas_start    (meas_start0),
        .result_strobe (strobe0),
        .accept_ready  (rdy0)
    );

    pcp_line_ctrl u_line1 (
        .pclk          (pclk),
        .presetn       (presetn),
        .trigger       (line1_trigger && multi && !diag),
        .continuous    (cont1 && !diag),
        .rx_ready      (line1_rx_ready_in),
        .handshake     (ctrl[`PCP_CTRL_HSHK_BIT]),
        .meas_start    (meas_start1),
        .result_strobe (strobe1),
        .accept_ready  (rdy1)
    );

    // =================================================================
    // Command interpreter, results and registers
    always_comb begin
        next_ctrl       = ctrl;
        next_force_out  = force_out;
        next_scene      = scene;
        next_group      = group;
        next_irq_enable = irq_enable;
        next_result     = result;
        next_overall    = overall;
        next_err        = err;
        next_exec_q     = cmd_in[7];
        next_info_q     = cmd_in[6:0];
        clear_pulse     = 1'b0;
        events          = 5'h00;
        // Count how long the info bits stood still
        if (cmd_in[6:0] != info_q) begin
            next_stable_cnt = 15'h0000;
        end else if (stable_cnt != SETUP_CYC) begin
            next_stable_cnt = stable_cnt + 15'h0001;
        end else begin
            next_stable_cnt = stable_cnt;
        end
        // Capture new results from the lines
        if (strobe0) begin
            // RULE11 line 0 low byte or whole word
            if (multi) begin
                next_result[7:0] = meas_result[7:0];
            end else begin
                next_result = meas_result;
            end
            next_overall[0] = meas_ok0;
        end
        if (strobe1 && multi) begin
            // RULE11 line 1 high byte
            next_result[15:8] = meas_result[15:8];
            next_overall[1]   = meas_ok1;
        end
        events[`PCP_IRQ_MEAS_BIT] = meas_start0 || meas_start1;
        if (exec_edge && !diag) begin
            // RULE3 setup time checked, RULE14 error on short setup
            if (stable_cnt != SETUP_CYC) begin
                next_err = 1'b1;
                events[`PCP_IRQ_ERR_BIT] = 1'b1;
            end else begin
                case (parallel_command_port_pkg::cmd_field_e'(cmd_in[6:5]))
                    // RULE4 info bits ignored
                    parallel_command_port_pkg::CMD_CONTINUOUS: begin
                        next_err = err;
                    end
                    // RULE5 scene switch
                    parallel_command_port_pkg::CMD_SCENE: begin
                        next_scene = multi ? {1'b0, cmd_in[3:0]} : cmd_in[4:0];
                        events[`PCP_IRQ_SCENE_BIT] = 1'b1;
                    end
                    // RULE6 scene group switch
                    parallel_command_port_pkg::CMD_GROUP: begin
                        next_group = multi ? {1'b0, cmd_in[3:0]} : cmd_in[4:0];
                        events[`PCP_IRQ_GROUP_BIT] = 1'b1;
                    end
                    parallel_command_port_pkg::CMD_CLEAR: begin
                        events[`PCP_IRQ_CLEAR_BIT] = 1'b1;
                        case ({multi ? 1'b0 : cmd_in[4], cmd_in[3:0]})
                            // RULE7 clear stored values only
                            parallel_command_port_pkg::CLR_VALUES: clear_pulse = 1'b1;
                            // RULE8 clear error
                            parallel_command_port_pkg::CLR_ERROR: next_err = 1'b0;
                            // RULE9 clear result outputs
                            parallel_command_port_pkg::CLR_RESULT: begin
                                next_result  = 16'h0000;
                                next_overall = 2'h0;
                            end
                            // RULE14 unknown clear code
                            default: begin
                                next_err = 1'b1;
                                events[`PCP_IRQ_ERR_BIT] = 1'b1;
                            end
                        endcase
                    end
                    default: next_err = 1'b1;
                endcase
            end
        end
        // Register writes
        if (wr_en) begin
            case (paddr)
                `PCP_CTRL_OFS:       next_ctrl       = pwdata[2:0];
                `PCP_FORCE_OUT_OFS:  next_force_out  = pwdata[22:0];
                `PCP_IRQ_ENABLE_OFS: next_irq_enable = pwdata[4:0];
                default:             next_ctrl       = ctrl;
            endcase
        end
        // Sticky status: set wins over clear
        next_irq_status = irq_status;
        if (wr_en && (paddr == `PCP_IRQ_CLEAR_OFS)) begin
            next_irq_status = irq_status & ~pwdata[4:0];
        end
        next_irq_status = next_irq_status | events;
        // Read data
        next_prdata = 32'h0000_0000;
        if (rd_en) begin
            case (paddr)
                `PCP_CTRL_OFS:       next_prdata = {29'h0, ctrl};
                // RULE13 live input levels
                `PCP_IN_STATUS_OFS:  next_prdata = {20'h0, line1_rx_ready_in, line0_rx_ready_in,
                                                    line1_trigger, line0_trigger, cmd_in};
                `PCP_FORCE_OUT_OFS:  next_prdata = {9'h0, force_out};
                `PCP_SCENE_OFS:      next_prdata = {19'h0, group, 3'h0, scene};
                `PCP_IRQ_STATUS_OFS: next_prdata = {27'h0, irq_status};
                `PCP_IRQ_ENABLE_OFS: next_prdata = {27'h0, irq_enable};
                `PCP_RESULT_OFS:     next_prdata = {13'h0, err, overall, result};
                default:             next_prdata = 32'h0000_0000;
            endcase
        end
    end

    // Register all state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl       <= 3'h0;
            force_out  <= 23'h000000;
            scene      <= 5'h00;
            group      <= 5'h00;
            irq_status <= 5'h00;
            irq_enable <= 5'h00;
            result     <= 16'h0000;
            overall    <= 2'h0;
            err        <= 1'b0;
            exec_q     <= 1'b0;
            stable_cnt <= 15'h0000;
            info_q     <= 7'h00;
            prdata     <= 32'h0000_0000;
            clear_values <= 1'b0;
        end else begin
            ctrl       <= next_ctrl;
            force_out  <= next_force_out;
            scene      <= next_scene;
            group      <= next_group;
            irq_status <= next_irq_status;
            irq_enable <= next_irq_enable;
            result     <= next_result;
            overall    <= next_overall;
            err        <= next_err;
            exec_q     <= next_exec_q;
            stable_cnt <= next_stable_cnt;
            info_q     <= next_info_q;
            prdata     <= next_prdata;
            clear_values <= clear_pulse;
        end
    end

    // =================================================================
    // Outputs: RULE12 diagnostic mode forces the line outputs, result_out and error_out; irq and the APB response are not forced
    assign result_out           = diag ? force_out[15:0] : result;
    assign line0_overall_result = diag ? force_out[`PCP_FORCE_OR0_BIT] : overall[0];
    assign line1_overall_result = diag ? force_out[`PCP_FORCE_OR1_BIT] : (multi && overall[1]);
    assign line0_result_strobe  = diag ? force_out[`PCP_FORCE_LINE0_RESULT_STROBE_BIT] : strobe0;
    assign line1_result_strobe  = diag ? force_out[`PCP_FORCE_LINE1_RESULT_STROBE_BIT] : (multi && strobe1);
    assign line0_accept_ready   = diag ? force_out[`PCP_FORCE_RDY0_BIT] : rdy0;
    assign line1_accept_ready   = diag ? force_out[`PCP_FORCE_RDY1_BIT] : (multi && rdy1);
    assign error_out            = diag ? force_out[`PCP_FORCE_ERR_BIT] : err;
    assign irq                  = |(irq_status & irq_enable);
    assign pready               = 1'b1;
    assign pslverr              = psel && penable && !addr_ok;

    // =================================================================
    // Checks
    a_exec_once: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
        !(exec_edge && !diag) |=> ($stable(scene) && $stable(group)))
        else $error("command acted without execute edge");

    a_clr_err: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
        (exec_edge && !diag && stable_cnt == SETUP_CYC && !multi && cmd_in[6:0] == 7'h41) |=> !err)
        else $error("error not cleared");

    a_short_setup: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
        (exec_edge && !diag && stable_cnt != SETUP_CYC) |=> err)
        else $error("short setup not flagged");

    a_clr_result: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
        (exec_edge && !diag && stable_cnt == SETUP_CYC && !multi && cmd_in[6:0] == 7'h42
         && !strobe0) |=> (result == 16'h0000))
        else $error("results not cleared");

    a_clr_values: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
        (clear_pulse && !strobe0 && !strobe1) |=> (clear_values && $stable(overall) && $stable(result)))
        else $error("value clear disturbed results");

    a_scene_set: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
        (exec_edge && !diag && !multi && stable_cnt == SETUP_CYC && cmd_in[6:5] == 2'b01)
        |=> scene == $past(cmd_in[4:0]))
        else $error("scene not taken");

    a_group_set: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
        (exec_edge && !diag && !multi && stable_cnt == SETUP_CYC && cmd_in[6:5] == 2'b11)
        |=> group == $past(cmd_in[4:0]))
        else $error("group not taken");

    a_cont_meas: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
        (cont0 && !diag) |-> meas_start0)
        else $error("continuous measure missing");

    a_diag_force: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
        diag |-> (result_out == force_out[15:0] && error_out == force_out[`PCP_FORCE_ERR_BIT]))
        else $error("diagnostic force not shown");

    a_one_line: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
        (!multi && !diag) |-> !line1_result_strobe)
        else $error("line 1 active in single mode");

endmodule

//--- parallel_command_port_regs.svh
// Register offsets, field positions, reset values and timing counts of the parallel command port
`ifndef PARALLEL_COMMAND_PORT_REGS_SVH
`define PARALLEL_COMMAND_PORT_REGS_SVH

// =====================================================================
// Register byte offsets
`define PCP_CTRL_OFS        12'h000
`define PCP_IN_STATUS_OFS   12'h004
`define PCP_FORCE_OUT_OFS   12'h008
`define PCP_SCENE_OFS       12'h00C
`define PCP_IRQ_STATUS_OFS  12'h010
`define PCP_IRQ_CLEAR_OFS   12'h014
`define PCP_IRQ_ENABLE_OFS  12'h018
`define PCP_RESULT_OFS      12'h01C

// =====================================================================
// Control register fields
`define PCP_CTRL_MULTI_BIT  0
`define PCP_CTRL_DIAG_BIT   1
`define PCP_CTRL_HSHK_BIT   2
`define PCP_CTRL_RESET      32'h0000_0000

// =====================================================================
// Force register fields: results in [15:0], then single outputs
`define PCP_FORCE_OR0_BIT   16
`define PCP_FORCE_OR1_BIT   17
`define PCP_FORCE_LINE0_RESULT_STROBE_BIT 18
`define PCP_FORCE_LINE1_RESULT_STROBE_BIT 19
`define PCP_FORCE_RDY0_BIT  20
`define PCP_FORCE_RDY1_BIT  21
`define PCP_FORCE_ERR_BIT   22

// =====================================================================
// Interrupt status bit positions
`define PCP_IRQ_MEAS_BIT    0
`define PCP_IRQ_SCENE_BIT   1
`define PCP_IRQ_GROUP_BIT   2
`define PCP_IRQ_CLEAR_BIT   3
`define PCP_IRQ_ERR_BIT     4

// =====================================================================
// Command timing: least setup of info before execute, in microseconds
`define PCP_CMD_SETUP_US    1000
`define PCP_CLK_MHZ         20
`define PCP_CMD_SETUP_CYC   (`PCP_CMD_SETUP_US * `PCP_CLK_MHZ)

`endif

//--- parallel_command_port_pkg.sv
// Types shared by the parallel command port
package parallel_command_port_pkg;

    // Command field of the command bus
    typedef enum logic [1:0] {
        CMD_CONTINUOUS = 2'b00,
        CMD_SCENE      = 2'b01,
        CMD_CLEAR      = 2'b10,
        CMD_GROUP      = 2'b11
    } cmd_field_e;

    // Information codes for the clear command
    typedef enum logic [4:0] {
        CLR_VALUES = 5'h00,
        CLR_ERROR  = 5'h01,
        CLR_RESULT = 5'h02
    } clear_code_e;

endpackage

//--- pcp_line_ctrl.sv
// One measurement line: trigger edge, result strobe and accept-ready handling
`timescale 1ns/1ps

module pcp_line_ctrl (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Line inputs
    input  wire logic trigger,        // Measurement trigger level
    input  wire logic continuous,     // Continuous measurement request
    input  wire logic rx_ready,       // Receive-ready from external party
    input  wire logic handshake,      // Handshake output control selected
    // Line outputs
    output logic      meas_start,     // Measurement start: one cycle per trigger edge, every cycle while continuous
    output logic      result_strobe,  // Result valid strobe
    output logic      accept_ready    // Line accepts a new trigger
);

    logic trig_q;          // Previous trigger level
    logic next_trig_q;
    logic strobe;          // Registered result strobe
    logic next_strobe;
    logic pend;            // Result waiting for permission
    logic next_pend;

    // =================================================================
    // Next state of the line
    always_comb begin
        next_trig_q = trigger;
        next_strobe = 1'b0;
        next_pend   = pend;
        meas_start  = (trigger && !trig_q) || continuous;
        // RULE1 one start per edge
        if (meas_start) begin
            next_pend = 1'b1;
        end
        // RULE2 handshake permission gate
        if (pend && (!handshake || rx_ready)) begin
            next_strobe = 1'b1;
            next_pend   = meas_start;
        end
    end

    // Register the line state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_q <= 1'b0;
            strobe <= 1'b0;
            pend   <= 1'b0;
        end else begin
            trig_q <= next_trig_q;
            strobe <= next_strobe;
            pend   <= next_pend;
        end
    end

    assign result_strobe = strobe;
    assign accept_ready  = !pend;

    // RULE1 trigger edge gives start
    a_trig_start: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
        (trigger && !$past(trigger)) |-> meas_start)
        else $error("trigger edge gave no start");

    // RULE2 no strobe without permission
    a_hshk_gate: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
        $rose(strobe) |-> $past(!handshake || rx_ready))
        else $error("result shown without receive ready");

endmodule

//--- pcp_host_model.sv
// External controller model driving trigger, receive-ready and command inputs
`timescale 1ns/1ps

module pcp_host_model (
    // Clock
    input  wire logic pclk,
    // Inputs of the port driven by the controller
    output logic       trig0,
    output logic       trig1,
    output logic       rx0,
    output logic [7:0] cmd
);
    // Idle levels; ready to receive until set_rx lowers rx0
    initial begin
        trig0 = 1'b0;
        trig1 = 1'b0;
        rx0   = 1'b1;
        cmd   = 8'h00;
    end

    task automatic send(input logic [6:0] code, input int hold);
        @(posedge pclk) cmd <= {1'b0, code};
        repeat (hold) @(posedge pclk);
        cmd[7] <= 1'b1;
        repeat (4) @(posedge pclk);
        cmd[7] <= 1'b0;
    endtask

    // Trigger pulse on the lines marked in which, a few cycles wide
    task automatic pulse(input logic [1:0] which);
        @(posedge pclk) {trig1, trig0} <= which;
        repeat (3) @(posedge pclk);
        {trig1, trig0} <= 2'b00;
    endtask

    task automatic set_rx(input logic v);
        @(posedge pclk) rx0 <= v;
    endtask
endmodule

//--- parallel_command_port_bench.sv
// Self-checking bench for the parallel command port
`timescale 1ns/1ps
`include "parallel_command_port_regs.svh"

module parallel_command_port_bench;
    // =====================================================================
    // Signals
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic        e, t0, t1, rx0, err_o, ms0, ms1, rdy0, ok;
    logic [7:0]  cmd;
    logic [15:0] res, mres;
    int          fail_count = 0;
    int          total_checks = 0;
    int          n;

    // Clock of 50 ns period
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // =====================================================================
    // Design and controller model
    pcp_host_model host (.pclk(pclk), .trig0(t0), .trig1(t1), .rx0(rx0), .cmd(cmd));
    parallel_command_port dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .line0_trigger(t0), .line1_trigger(t1), .line0_rx_ready_in(rx0),
        .line1_rx_ready_in(1'b0), .cmd_in(cmd), .meas_result(mres), .meas_ok0(ok),
        .meas_ok1(ok), .line0_result_strobe(), .line1_result_strobe(),
        .line0_overall_result(), .line1_overall_result(), .line0_accept_ready(rdy0),
        .line1_accept_ready(), .result_out(res), .error_out(err_o), .meas_start0(ms0),
        .meas_start1(ms1), .clear_values(), .irq(irq));

    // =====================================================================
    // Reporting
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Compare one 32-bit result
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // APB transfer; read data and response taken at the completing edge, then one idle cycle
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int k;
        k = 0;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk) penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 50) begin
            k++;
            @(posedge pclk);
        end
        if (k == 50) begin
            fail_count++;
            conclude();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // =====================================================================
    // Test sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        mres = 16'h5AC3;
        ok = 1'b1;
        presetn = 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `PCP_CTRL_OFS, 32'h0, r, e);
        chk(r, 32'h0);
        apb(1'b1, `PCP_IRQ_ENABLE_OFS, 32'h1F, r, e);
        n = 0;
        fork
            host.pulse(2'b01);
            repeat (12) @(posedge pclk) n += int'(ms0 === 1'b1);
        join
        chk(n, 1);
        apb(1'b0, `PCP_RESULT_OFS, 32'h0, r, e);
        chk(r, 32'h0001_5AC3);
        host.send(7'h3F, 20001);
        apb(1'b0, `PCP_SCENE_OFS, 32'h0, r, e);
        chk(r, 32'h1F);
        apb(1'b0, `PCP_IN_STATUS_OFS, 32'h0, r, e);
        chk(r, 32'h43F);
        host.send(7'h69, 1);
        chk({31'h0, err_o}, 32'h1);
        n = 0;
        fork
            host.send(7'h00, 1);
            repeat (8) @(posedge pclk) n += int'(ms0 === 1'b1);
        join
        chk(n, 4);
        host.send(7'h41, 20001);
        chk({31'h0, err_o}, 32'h0);
        host.send(7'h69, 20001);
        apb(1'b0, `PCP_SCENE_OFS, 32'h0, r, e);
        chk(r, 32'h91F);
        host.send(7'h42, 20001);
        apb(1'b0, `PCP_RESULT_OFS, 32'h0, r, e);
        chk(r, 32'h0);
        chk({16'h0, res}, 32'h0);
        apb(1'b0, `PCP_IRQ_STATUS_OFS, 32'h0, r, e);
        chk({r[30:0], irq}, 32'h3F);
        apb(1'b1, `PCP_IRQ_CLEAR_OFS, 32'h1F, r, e);
        apb(1'b0, `PCP_IRQ_STATUS_OFS, 32'h0, r, e);
        chk({r[30:0], irq}, 32'h0);
        apb(1'b0, 12'h020, 32'h0, r, e);
        chk({r[30:0], e}, 32'h1);
        apb(1'b1, `PCP_CTRL_OFS, 32'h1, r, e);
        n = 0;
        fork
            host.pulse(2'b10);
            repeat (12) @(posedge pclk) n += int'(ms1 === 1'b1) + int'(ms0 === 1'b1) * 16;
        join
        chk(n, 1);
        apb(1'b0, `PCP_RESULT_OFS, 32'h0, r, e);
        chk(r, 32'h0002_5A00);
        apb(1'b1, `PCP_CTRL_OFS, 32'h4, r, e);
        host.set_rx(1'b0);
        host.pulse(2'b01);
        chk({31'h0, rdy0}, 32'h0);
        host.set_rx(1'b1);
        repeat (2) @(posedge pclk);
        chk({31'h0, rdy0}, 32'h1);
        apb(1'b1, `PCP_CTRL_OFS, 32'h2, r, e);
        apb(1'b1, `PCP_FORCE_OUT_OFS, 32'h0040_A5C3, r, e);
        chk({15'h0, err_o, res}, 32'h0001_A5C3);
        apb(1'b1, `PCP_CTRL_OFS, 32'h0, r, e);
        conclude();
    end
endmodule
